/* rtl/dgc_pkg.sv */
// Constants, encodings and register offsets of the general command handler.
// Assumes a single system clock domain with synchronous active-high reset.
`default_nettype none
package dgc_pkg;
	// ======================================================================
	// Command opcodes
	localparam logic [7:0] OP_POWER = 8'h10;
	localparam logic [7:0] OP_DISPLAY = 8'h11;
	localparam logic [7:0] OP_LOW_LAT = 8'h12;
	localparam logic [7:0] OP_LOOK = 8'h13;
	localparam logic [7:0] OP_PATTERN = 8'h14;
	localparam logic [7:0] OP_RESOURCE = 8'hf2;
	localparam logic [7:0] OP_FREE_AREA = 8'hff;
	// ======================================================================
	// Register offsets
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_PARAM = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_RESP_LO = 4'h3;
	localparam logic [3:0] REG_RESP_MID = 4'h4;
	localparam logic [3:0] REG_RESP_HI = 4'h5;
	localparam logic [3:0] REG_CONFIG = 4'h6;
	// ======================================================================
	// Field encodings
	localparam logic [7:0] PWR_RESET = 8'h00;
	localparam logic [7:0] PWR_STANDBY = 8'h01;
	localparam logic [7:0] PWR_ACTIVE = 8'h02;
	localparam logic [7:0] SRC_EXTERNAL = 8'h00;
	localparam logic [7:0] SRC_PATTERN = 8'h01;
	localparam logic [7:0] SRC_SOLID = 8'h02;
	localparam logic [7:0] SRC_SPLASH = 8'h03;
	localparam logic [7:0] SRC_CURTAIN = 8'h04;
	localparam int RES_BYTES = 12;
	localparam int RES_COUNTERS = 6;
	localparam logic [3:0] RES_LEN = 4'hc;
	localparam logic [3:0] FREE_LEN = 4'h2;
	localparam logic [3:0] ONE_LEN = 4'h1;
	localparam logic [3:0] TWO_LEN = 4'h2;
	localparam logic [3:0] NO_LEN = 4'h0;
	localparam int ERR_BIT = 0;
	localparam int LEN_LSB = 4;
	localparam int PTR_LSB = 8;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_QUERY = 3'b010,
		ST_APPLY = 3'b100
	} dgc_state_type;
endpackage
`default_nettype wire

/* rtl/dgc_resource_counter.sv */
// One resource tracker: current count and high-water mark.
// Assumes alloc and free are one-cycle pulses from the same clock domain.
`default_nettype none
module dgc_resource_counter
(
	input wire logic clk,
	input wire logic rst,
	input wire logic alloc,
	input wire logic free,
	output logic [7:0] current,
	output logic [7:0] high
);
	typedef struct packed
	{
		logic [7:0] cur;
		logic [7:0] hi;
	} dgc_rc_type;
	dgc_rc_type r_q, r_d;
	always_comb
	begin
		r_d = r_q;
		if (alloc && !free && r_q.cur != 8'hff)
			r_d.cur = r_q.cur + 8'h01;
		else if (free && !alloc && r_q.cur != 8'h00)
			r_d.cur = r_q.cur - 8'h01;
		// The mark follows the new count so it never lags one allocation.
		if (r_d.cur > r_q.hi)
			r_d.hi = r_d.cur;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			r_q <= '0;
		else
			r_q <= r_d;
	end
	assign current = r_q.cur;
	assign high = r_q.hi;
endmodule
`default_nettype wire

/* rtl/dgc_handler.sv */
// General-operation command handler with register port to the host.
// Assumes host strobes are synchronous to clk; source_present passes a two-stage sync.
//
// The address map and the plain strobed port were decided locally.
`default_nettype none
module dgc_handler
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic source_present,
	input wire logic [15:0] free_area_offset,
	input wire logic [5:0] res_alloc,
	input wire logic [5:0] res_free,
	output logic [1:0] power_state,
	output logic power_down,
	output logic [7:0] shown_source,
	output logic low_latency_en,
	output logic [7:0] latency_frames_x2,
	output logic [15:0] look_index,
	output logic look_load,
	output logic source_change,
	output logic [7:0] pattern_number,
	output logic pattern_load,
	output logic cmd_error
);
	import dgc_pkg::*;

	// ======================================================================
	// State
	typedef struct packed
	{
		dgc_state_type st;
		logic [7:0] op;
		logic [15:0] param;
		logic [7:0] pwr;
		logic pdown;
		logic [7:0] src;
		logic low_lat;
		logic [15:0] look;
		logic [7:0] pat;
		logic splash_default;
		logic err;
		logic look_ld;
		logic src_chg;
		logic pat_ld;
		logic [RES_BYTES-1:0][7:0] resp;
		logic [3:0] len;
		logic [31:0] rdata;
		logic sp_m;
		logic sp_s;
	} dgc_core_type;

	dgc_core_type s_q, s_d;
	logic [7:0] res_cur [RES_COUNTERS];
	logic [7:0] res_high [RES_COUNTERS];
	logic [7:0] shown;

	// ======================================================================
	// Resource trackers
	for (genvar g = 0; g < RES_COUNTERS; g++)
	begin : g_res
		dgc_resource_counter u_cnt
		(
			.clk(clk),
			.rst(rst),
			.alloc(res_alloc[g]),
			.free(res_free[g]),
			.current(res_cur[g]),
			.high(res_high[g])
		);
	end

	function automatic logic [31:0] pack_word(input logic [3:0] base,
		input dgc_core_type s);
		logic [31:0] w;
		w = '0;
		for (int i = 0; i < 4; i++)
			if (int'(base) + i < RES_BYTES)
				w[i*8 +: 8] = s.resp[int'(base) + i];
		return w;
	endfunction

	// Without a live input the external source falls back to the default.
	always_comb
	begin
		shown = s_q.src;
		if (s_q.src == SRC_EXTERNAL && !s_q.sp_s)
			shown = s_q.splash_default ? SRC_SPLASH : SRC_SOLID;
	end

	// ======================================================================
	// Command engine
	always_comb
	begin
		s_d = s_q;
		s_d.sp_m = source_present;
		s_d.sp_s = s_q.sp_m;
		s_d.look_ld = 1'b0;
		s_d.src_chg = 1'b0;
		s_d.pat_ld = 1'b0;
		s_d.rdata = '0;
		if (reg_write && reg_addr == REG_PARAM)
			s_d.param = reg_wdata[15:0];
		if (reg_write && reg_addr == REG_CONFIG)
			s_d.splash_default = reg_wdata[0];
		if (reg_write && reg_addr == REG_CMD && s_q.st == ST_IDLE)
		begin
			s_d.op = reg_wdata[7:0];
			s_d.err = 1'b0;
			s_d.st = reg_wdata[8] ? ST_QUERY : ST_APPLY;
		end
		unique case (s_q.st)
			ST_IDLE:
			begin
			end
			ST_QUERY:
			begin
				s_d.st = ST_IDLE;
				for (int i = 0; i < RES_BYTES; i++)
					s_d.resp[i] = 8'h00;
				s_d.len = ONE_LEN;
				unique case (s_q.op)
					OP_RESOURCE:
					begin
						for (int i = 0; i < RES_COUNTERS; i++)
						begin
							s_d.resp[i] = res_high[i];
							s_d.resp[i + RES_COUNTERS] = res_cur[i];
						end
						s_d.len = RES_LEN;
					end
					OP_FREE_AREA:
					begin
						s_d.resp[0] = free_area_offset[7:0];
						s_d.resp[1] = free_area_offset[15:8];
						s_d.len = FREE_LEN;
					end
					OP_POWER:
						s_d.resp[0] = s_q.pwr;
					OP_DISPLAY:
						s_d.resp[0] = shown;
					OP_LOW_LAT:
						s_d.resp[0] = {7'h00, s_q.low_lat};
					OP_LOOK:
					begin
						s_d.resp[0] = s_q.look[7:0];
						s_d.resp[1] = s_q.look[15:8];
						s_d.len = TWO_LEN;
					end
					OP_PATTERN:
						s_d.resp[0] = s_q.pat;
					default:
					begin
						s_d.err = 1'b1;
						s_d.len = NO_LEN;
					end
				endcase
			end
			ST_APPLY:
			begin
				s_d.st = ST_IDLE;
				s_d.len = NO_LEN;
				unique case (s_q.op)
					OP_POWER:
						if (s_q.pwr == PWR_STANDBY)
							s_d.pwr = PWR_ACTIVE;
						else if (s_q.pwr == PWR_ACTIVE)
						begin
							s_d.pwr = PWR_STANDBY;
							s_d.pdown = 1'b1;
						end
						else
						begin
							s_d.pwr = PWR_STANDBY;
							s_d.pdown = 1'b0;
						end
					OP_DISPLAY:
						if (s_q.param[7:0] <= SRC_CURTAIN && s_q.param[15:8] == 8'h00)
							s_d.src = s_q.param[7:0];
						else
							s_d.err = 1'b1;
					OP_LOW_LAT:
						if (s_q.param[15:1] == 15'h0000)
							s_d.low_lat = s_q.param[0];
						else
							s_d.err = 1'b1;
					OP_LOOK:
					begin
						s_d.look = s_q.param;
						s_d.look_ld = 1'b1;
						s_d.src_chg = 1'b1;
					end
					OP_PATTERN:
						if (s_q.param[15:8] == 8'h00)
						begin
							s_d.pat = s_q.param[7:0];
							s_d.pat_ld = 1'b1;
						end
						else
							s_d.err = 1'b1;
					default:
						s_d.err = 1'b1;
				endcase
			end
			default:
				s_d.st = ST_IDLE;
		endcase
		// ==================================================================
		// Register read port
		if (reg_read)
		begin
			unique case (reg_addr)
				REG_PARAM:
					s_d.rdata = {16'h0000, s_q.param};
				REG_STATUS:
				begin
					s_d.rdata[ERR_BIT] = s_q.err;
					s_d.rdata[1] = (s_q.st != ST_IDLE);
					s_d.rdata[LEN_LSB +: 4] = s_q.len;
					s_d.rdata[PTR_LSB +: 8] = shown;
				end
				REG_RESP_LO:
					s_d.rdata = pack_word(4'h0, s_q);
				REG_RESP_MID:
					s_d.rdata = pack_word(4'h4, s_q);
				REG_RESP_HI:
					s_d.rdata = pack_word(4'h8, s_q);
				REG_CONFIG:
					s_d.rdata = {31'h0, s_q.splash_default};
				default:
					s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.pwr <= PWR_STANDBY;
			s_q.splash_default <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// ======================================================================
	// Outputs
	// Latency budget is expressed in half frames so the datapath can compare
	// directly; three half frames is the low-latency ceiling.
	assign latency_frames_x2 = s_q.low_lat ? 8'h03 : 8'hff;
	assign reg_rdata = s_q.rdata;
	assign power_state = s_q.pwr[1:0];
	assign power_down = s_q.pdown;
	assign shown_source = shown;
	assign low_latency_en = s_q.low_lat;
	assign look_index = s_q.look;
	assign look_load = s_q.look_ld;
	assign source_change = s_q.src_chg;
	assign pattern_number = s_q.pat;
	assign pattern_load = s_q.pat_ld;
	assign cmd_error = s_q.err;
endmodule
`default_nettype wire

/* dv/dgc_handler_assertions.sv */
// Checker of the command handler's outputs.
// Assumes one clock domain and a bind to every dgc_handler.
`default_nettype none
module dgc_handler_checker
(
	input wire logic clk,
	input wire logic rst,
	input wire logic source_present,
	input wire logic [1:0] power_state,
	input wire logic power_down,
	input wire logic [7:0] shown_source,
	input wire logic low_latency_en,
	input wire logic [7:0] latency_frames_x2,
	input wire logic [15:0] look_index,
	input wire logic look_load,
	input wire logic source_change,
	input wire logic [7:0] pattern_number,
	input wire logic pattern_load,
	input wire logic cmd_error
);
	// ======
	// Properties
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	a_look_pulses: assert property ($changed(look_index) |->
		look_load && source_change) else $error("look pulses");
	a_pattern_pulse: assert property ($changed(pattern_number) |->
		pattern_load) else $error("pattern pulse");
	a_power_codes: assert property (power_state inside {2'd1, 2'd2})
		else $error("power code");
	a_power_toggle: assert property ($rose(power_down) |->
		$past(power_state) == 2'd2 && power_state == 2'd1) else $error("toggle");
	a_source_range: assert property (shown_source <= 8'h04)
		else $error("source code");
	// Three samples cover the two-stage synchroniser ahead of the mux.
	a_signal_fallback: assert property (!source_present [*3] |->
		shown_source != 8'h00) else $error("fallback");
	a_latency_budget: assert property (low_latency_en |->
		latency_frames_x2 <= 8'h03) else $error("latency");
	a_error_holds: assert property ($rose(cmd_error) |->
		$stable(pattern_number) && $stable(look_index) && $stable(low_latency_en))
		else $error("setting moved");
	cover property (look_load);
	cover property ($rose(power_down));
	cover property ($rose(cmd_error));
endmodule
bind dgc_handler dgc_handler_checker chk (.clk, .rst, .source_present,
	.power_state, .power_down, .shown_source, .low_latency_en,
	.latency_frames_x2, .look_index, .look_load, .source_change,
	.pattern_number, .pattern_load, .cmd_error);
`default_nettype wire

/* dv/dgc_host_model.sv */
// Host processor model driving the register port.
// Assumes read data stand only in the cycle after the read strobe.
`default_nettype none
module dgc_host_model
(
	input wire logic clk,
	input wire logic [31:0] reg_rdata,
	output logic [3:0] reg_addr,
	output logic [31:0] reg_wdata,
	output logic reg_write,
	output logic reg_read
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	// ======
	// Bus cycles
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		// Stale data is inverted so nothing leans on it.
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

/* dv/dgc_handler_bench.sv */
// Self-checking bench of the general command handler.
// Assumes the host model issues commands and the bench drives the pins.
`default_nettype none
module dgc_handler_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import dgc_pkg::*;
	logic clk = 1'b0;
	logic rst, reg_write, reg_read, source_present, power_down;
	logic low_latency_en, look_load, source_change, pattern_load, cmd_error;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] free_area_offset, look_index;
	logic [5:0] res_alloc, res_free;
	logic [1:0] power_state;
	logic [7:0] shown_source, latency_frames_x2, pattern_number;
	int mismatches = 0;
	int samples_checked = 0;
	always #10 clk = ~clk;
	dgc_handler dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .source_present, .free_area_offset, .res_alloc, .res_free,
		.power_state, .power_down, .shown_source, .low_latency_en,
		.latency_frames_x2, .look_index, .look_load, .source_change,
		.pattern_number, .pattern_load, .cmd_error);
	dgc_host_model host (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_write,
		.reg_read);
	// ======
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: saw %h not %h", $time, seen, exp);
		end
	endtask
	// Settings land two edges after the command strobe.
	task automatic cmd(input logic [7:0] op, input logic q, input logic [31:0] p);
		host.wr(REG_PARAM, p);
		host.wr(REG_CMD, {23'h0, q, op});
		repeat (2) @(posedge clk);
	endtask
	task automatic get(input logic [7:0] op, output logic [31:0] d);
		cmd(op, 1'b1, 32'h0);
		host.rd(REG_RESP_LO, d);
	endtask
	task automatic wrap_up;
		$display("mismatches %0d samples_checked %0d", mismatches,
			samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ======
	// Scenarios
	task automatic t_resource;
		logic [31:0] d;
		for (int k = 0; k < 6; k++)
		begin
			res_alloc <= 6'h3f << k;
			@(posedge clk);
		end
		res_alloc <= 6'h0;
		res_free <= 6'h3f;
		@(posedge clk);
		res_free <= 6'h0;
		get(OP_RESOURCE, d);
		chk(d, 32'h04030201);
		host.rd(REG_STATUS, d);
		chk(d[7:0], {RES_LEN, 4'h0});
		host.rd(REG_RESP_MID, d);
		chk(d, 32'h01000605);
		host.rd(REG_RESP_HI, d);
		chk(d, 32'h05040302);
		free_area_offset <= 16'ha5c3;
		get(OP_FREE_AREA, d);
		chk(d[15:0], 16'ha5c3);
	endtask
	task automatic t_display;
		logic [31:0] d;
		source_present <= 1'b1;
		for (int s = 0; s < 5; s++)
		begin
			cmd(OP_DISPLAY, 1'b0, s);
			chk(shown_source, s);
			get(OP_DISPLAY, d);
			chk(d[7:0], s);
		end
		cmd(OP_DISPLAY, 1'b0, 32'h5);
		chk({cmd_error, shown_source}, {1'b1, SRC_CURTAIN});
		cmd(OP_DISPLAY, 1'b0, 32'h0);
		source_present <= 1'b0;
		repeat (4) @(posedge clk);
		chk(shown_source, SRC_SPLASH);
		host.wr(REG_CONFIG, 32'h0);
		@(posedge clk);
		chk(shown_source, SRC_SOLID);
		get(OP_DISPLAY, d);
		chk(d[7:0], SRC_SOLID);
	endtask
	task automatic t_settings;
		logic [31:0] d;
		cmd(OP_LOW_LAT, 1'b0, 32'h1);
		chk({low_latency_en, latency_frames_x2}, 9'h103);
		get(OP_LOW_LAT, d);
		chk(d[7:0], 8'h01);
		cmd(OP_LOW_LAT, 1'b0, 32'h2);
		chk({cmd_error, low_latency_en}, 2'b11);
		cmd(OP_LOW_LAT, 1'b0, 32'h0);
		chk({cmd_error, low_latency_en}, 2'b00);
		chk(latency_frames_x2, 8'hff);
		cmd(8'h20, 1'b0, 32'h0);
		chk({cmd_error, low_latency_en}, 2'b10);
		cmd(OP_LOOK, 1'b0, 32'h1234);
		chk({look_load, source_change, look_index}, 18'h31234);
		get(OP_LOOK, d);
		chk(d[15:0], 16'h1234);
		cmd(OP_DISPLAY, 1'b0, SRC_PATTERN);
		cmd(OP_PATTERN, 1'b0, 32'h7);
		chk({pattern_load, pattern_number}, 9'h107);
		get(OP_PATTERN, d);
		chk(d[7:0], 8'h07);
		cmd(OP_PATTERN, 1'b0, 32'h109);
		chk({cmd_error, pattern_number}, 9'h107);
	endtask
	task automatic t_power;
		logic [31:0] d;
		get(OP_POWER, d);
		chk(d[7:0], PWR_STANDBY);
		cmd(OP_POWER, 1'b0, 32'h0);
		chk(power_state, 2'd2);
		get(OP_POWER, d);
		chk(d[7:0], PWR_ACTIVE);
		cmd(OP_POWER, 1'b0, 32'h0);
		chk(power_down, 1'b1);
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		wrap_up;
	end
	initial
	begin
		rst = 1'b1;
		source_present = 1'b0;
		free_area_offset = 16'h0;
		res_alloc = 6'h0;
		res_free = 6'h0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_resource;
		t_display;
		t_settings;
		t_power;
		wrap_up;
	end
endmodule
`default_nettype wire
